// [hdl/isw_params.svh]
// constants for the interrupt and sleep/wake-up controller
`ifndef ISW_PARAMS_SVH
`define ISW_PARAMS_SVH
`define ISW_NUM_LINES 7
`define ISW_VECTOR 16'h0010
`define ISW_SP_STEP 8'h02
`define ISW_SP_RST 8'h00
`define ISW_GIE_RST 1'b0
`define ISW_WAKE_NORMAL 12'd3000
`define ISW_WAKE_FAST 12'd45
`define ISW_CMP_EN_BIT 7
`define ISW_CMP_WAKE_BIT 6
`define ISW_AUX_FAST_BIT 5
`define ISW_EDGE_BOTH 2'h0
`define ISW_EDGE_RISE 2'h1
`define ISW_EDGE_FALL 2'h2
`define ISW_LINE_EXTA 0
`define ISW_LINE_EXTB 1
`define ISW_LINE_ADC 2
`define ISW_LINE_T16 3
`define ISW_LINE_CMP 4
`define ISW_LINE_T2 5
`define ISW_LINE_T3 6
`endif

// [hdl/isw_pkg.sv]
// types shared by the interrupt and sleep/wake-up controller
package isw_pkg;
  typedef enum logic [1:0] {ISW_RUN, ISW_LIGHT, ISW_DEEP, ISW_WAKE} isw_pwr_t;
  typedef enum logic [1:0] {ISW_POP_NONE, ISW_POP_PC, ISW_POP_AF} isw_pop_t;
endpackage : isw_pkg

// [hdl/isw_stack_mem.sv]
// word-wide stack memory with registered read data
module isw_stack_mem #(
  parameter int AW = 7,
  parameter int DW = 16
) (
  input wire logic clk,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [DW-1:0] wrData,
  input wire logic [AW-1:0] rdAddr,
  output logic [DW-1:0] rdData
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // write port
  always_ff @(posedge clk)
  begin
    if (wrEn)
    begin
      mem[wrAddr] <= wrData;
    end
  end

  // registered read port
  always_ff @(posedge clk)
  begin
    rdData <= mem[rdAddr];
  end
endmodule : isw_stack_mem

// [hdl/isw_ctrl.sv]
// interrupt request, stack and sleep/wake-up control
`include "isw_params.svh"
module isw_ctrl
  import isw_pkg::*;
#(
  parameter int NPINS = 14,
  parameter int SPW = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] extPins,
  input wire logic [1:0] extPinSel,
  input wire logic adcEvt,
  input wire logic t16Evt,
  input wire logic cmpEvt,
  input wire logic t2Evt,
  input wire logic t3Evt,
  input wire logic [13:0] edgeSel,
  input wire logic [6:0] irqLineEnable,
  input wire logic flagWrStb,
  input wire logic [6:0] flagWrData,
  output logic [6:0] irqFlags,
  input wire logic instrBoundary,
  input wire logic engintCmd,
  input wire logic disgintCmd,
  input wire logic retiCmd,
  input wire logic pushafCmd,
  input wire logic popafCmd,
  input wire logic [15:0] pcIn,
  input wire logic [7:0] accumulator,
  input wire logic [7:0] flagReg,
  input wire logic spWrStb,
  input wire logic [SPW-1:0] spWrData,
  output logic [SPW-1:0] stackPointer,
  output logic globalEnable,
  output logic irqTake,
  output logic [15:0] vectorPc,
  output logic restoreValid,
  output logic [15:0] restorePc,
  output logic [7:0] restoreAcc,
  output logic [7:0] restoreFlag,
  input wire logic lightSleepCmd,
  input wire logic deepSleepCmd,
  input wire logic [NPINS-1:0] ioPins,
  input wire logic [NPINS-1:0] portDigitalInputEnable,
  input wire logic [2:0] timerClkIsCore,
  input wire logic [2:0] timerOscOn,
  input wire logic [2:0] timerMatch,
  input wire logic [7:0] comparatorControl,
  input wire logic [7:0] comparatorSelect,
  input wire logic [7:0] auxControl,
  input wire logic fastBootOpt,
  input wire logic slowRcClk,
  output logic coreClkEn,
  output logic progMemOn,
  output logic oscKeepOn,
  output logic slowRcEn,
  output logic [2:0] timerRun,
  output logic wakeDone
);
  localparam int SW = 4 + NPINS + 1;

  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic [SW-1:0] syncA_r, syncB_r, syncPrev_r;
  logic [3:0] extS;
  logic [NPINS-1:0] pinS, pinPrev;
  logic rcS, rcPrev, rcTick;

  // two flops for every pin-level input
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      syncA_r <= '0;
      syncB_r <= '0;
      syncPrev_r <= '0;
    end
    else
    begin
      syncA_r <= {slowRcClk, ioPins, extPins};
      syncB_r <= syncA_r;
      syncPrev_r <= syncB_r;
    end
  end
  assign extS = syncB_r[3:0];
  assign pinS = syncB_r[4 +: NPINS];
  assign pinPrev = syncPrev_r[4 +: NPINS];
  assign rcS = syncB_r[SW-1];
  assign rcPrev = syncPrev_r[SW-1];
  assign rcTick = rcS & ~rcPrev;

  // ************************************************************
  // request flags
  // ************************************************************
  logic [6:0] src, srcPrev_r, setVec, flags_r, flags_nxt;

  assign src[`ISW_LINE_EXTA] = extPinSel[0] ? extS[1] : extS[0];
  assign src[`ISW_LINE_EXTB] = extPinSel[1] ? extS[3] : extS[2];
  assign src[`ISW_LINE_ADC] = adcEvt;
  assign src[`ISW_LINE_T16] = t16Evt;
  assign src[`ISW_LINE_CMP] = cmpEvt;
  assign src[`ISW_LINE_T2] = t2Evt;
  assign src[`ISW_LINE_T3] = t3Evt;

  // previous source level for edge detection
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      srcPrev_r <= '0;
    end
    else
    begin
      srcPrev_r <= src;
    end
  end

  for (genvar i = 0; i < `ISW_NUM_LINES; i++)
  begin : gLine
    logic rise, fall;
    assign rise = src[i] & ~srcPrev_r[i];
    assign fall = ~src[i] & srcPrev_r[i];
    assign setVec[i] = (edgeSel[2*i +: 2] == `ISW_EDGE_RISE) ? rise :
                       (edgeSel[2*i +: 2] == `ISW_EDGE_FALL) ? fall : (rise | fall);
  end

  // set regardless of enable, set beats clear
  assign flags_nxt = (flagWrStb ? (flags_r & flagWrData) : flags_r) | setVec;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flags_r <= '0;
    end
    else
    begin
      flags_r <= flags_nxt;
    end
  end
  assign irqFlags = flags_r;

  // ************************************************************
  // global enable, entry, return and stack
  // ************************************************************
  logic gie_r, pendingAny, popPc, popAf, pushAf;
  logic [SPW-1:0] sp_r, spDown;
  isw_pop_t popKind_r;
  logic memWr;
  logic [15:0] memWrData, memRd;
  logic [SPW-2:0] memWrAddr, memRdAddr;

  assign pendingAny = |(flags_r & irqLineEnable);
  assign irqTake = instrBoundary & gie_r & pendingAny & ~retiCmd & ~pushafCmd & ~popafCmd;
  assign popPc = retiCmd & ~irqTake;
  assign pushAf = pushafCmd & ~irqTake;
  assign popAf = popafCmd & ~irqTake & ~retiCmd;
  assign spDown = sp_r - `ISW_SP_STEP;
  assign vectorPc = `ISW_VECTOR;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gie_r <= `ISW_GIE_RST;
    end
    else if (irqTake | disgintCmd)
    begin
      gie_r <= 1'b0;
    end
    else if (popPc | engintCmd)
    begin
      gie_r <= 1'b1;
    end
  end
  assign globalEnable = gie_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sp_r <= `ISW_SP_RST;
    end
    else if (irqTake | pushAf)
    begin
      sp_r <= sp_r + `ISW_SP_STEP;
    end
    else if (popPc | popAf)
    begin
      sp_r <= spDown;
    end
    else if (spWrStb)
    begin
      sp_r <= spWrData;
    end
  end
  assign stackPointer = sp_r;

  assign memWr = irqTake | pushAf;
  assign memWrAddr = sp_r[SPW-1:1];
  assign memWrData = irqTake ? pcIn : {accumulator, flagReg};
  assign memRdAddr = spDown[SPW-1:1];

  isw_stack_mem #(.AW(SPW-1), .DW(16)) uStack (
    .clk(clk),
    .wrEn(memWr),
    .wrAddr(memWrAddr),
    .wrData(memWrData),
    .rdAddr(memRdAddr),
    .rdData(memRd)
  );

  // remembers which pop is in flight
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      popKind_r <= ISW_POP_NONE;
    end
    else
    begin
      popKind_r <= popPc ? ISW_POP_PC : (popAf ? ISW_POP_AF : ISW_POP_NONE);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      restoreValid <= 1'b0;
      restorePc <= '0;
      restoreAcc <= '0;
      restoreFlag <= '0;
    end
    else
    begin
      restoreValid <= popKind_r != ISW_POP_NONE;
      if (popKind_r == ISW_POP_PC)
      begin
        restorePc <= memRd;
      end
      if (popKind_r == ISW_POP_AF)
      begin
        restoreAcc <= memRd[15:8];
        restoreFlag <= memRd[7:0];
      end
    end
  end

  // ************************************************************
  // sleep and wake-up
  // ************************************************************
  isw_pwr_t pwr_r;
  logic [11:0] wakeCnt_r, wakeTarget;
  logic pinToggle, timerWake, cmpWake, fastWake;

  assign pinToggle = |((pinS ^ pinPrev) & portDigitalInputEnable);
  // timer wake only off the core clock
  assign timerWake = |(timerMatch & ~timerClkIsCore & timerOscOn);
  assign cmpWake = cmpEvt & comparatorControl[`ISW_CMP_EN_BIT] & comparatorSelect[`ISW_CMP_WAKE_BIT];
  assign fastWake = fastBootOpt | auxControl[`ISW_AUX_FAST_BIT];
  assign wakeTarget = fastWake ? `ISW_WAKE_FAST : `ISW_WAKE_NORMAL;

  // power state sequencing
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pwr_r <= ISW_RUN;
      wakeCnt_r <= '0;
      wakeDone <= 1'b0;
    end
    else
    begin
      wakeDone <= 1'b0;
      unique case (pwr_r)
        ISW_RUN:
        begin
          wakeCnt_r <= '0;
          if (deepSleepCmd)
          begin
            pwr_r <= ISW_DEEP;
          end
          else if (lightSleepCmd)
          begin
            pwr_r <= ISW_LIGHT;
          end
        end
        ISW_LIGHT:
        begin
          if (pinToggle)
          begin
            pwr_r <= ISW_WAKE;
          end
          else if (timerWake | cmpWake)
          begin
            pwr_r <= ISW_RUN;
            wakeDone <= 1'b1;
          end
        end
        ISW_DEEP:
        begin
          if (pinToggle)
          begin
            pwr_r <= ISW_WAKE;
          end
        end
        ISW_WAKE:
        begin
          // count slow RC clocks, then resume
          if (rcTick)
          begin
            if (wakeCnt_r + 12'd1 >= wakeTarget)
            begin
              pwr_r <= ISW_RUN;
              wakeDone <= 1'b1;
            end
            wakeCnt_r <= wakeCnt_r + 12'd1;
          end
        end
      endcase
    end
  end

  assign coreClkEn = pwr_r == ISW_RUN;
  assign progMemOn = pwr_r == ISW_RUN;
  assign oscKeepOn = pwr_r != ISW_DEEP;
  assign slowRcEn = pwr_r != ISW_DEEP;
  assign timerRun = (pwr_r == ISW_RUN) ? 3'h7 :
                    (pwr_r == ISW_LIGHT) ? (~timerClkIsCore & timerOscOn) : 3'h0;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence seqReti;
    retiCmd && !irqTake;
  endsequence
  sequence seqRestore;
    ##2 restoreValid;
  endsequence

  AST_ENTRY_SP: assert property (irqTake |=> stackPointer == $past(stackPointer) + 8'h02)
    else $error("sp not advanced by two on entry");
  AST_ENTRY_GIE: assert property (irqTake |=> !globalEnable)
    else $error("global enable not cleared on entry");
  AST_RETI: assert property (seqReti |-> seqRestore)
    else $error("reti gave no restore two cycles later");
  AST_RETI_GIE: assert property (seqReti |=> globalEnable && stackPointer == $past(stackPointer) - 8'h02)
    else $error("reti did not re-enable or step sp down");
  AST_TAKE_COND: assert property (irqTake |-> globalEnable && (irqFlags & irqLineEnable) != 0)
    else $error("interrupt taken without enabled pending request");
  AST_FLAG_SET: assert property (setVec[0] |=> irqFlags[0])
    else $error("edge on line 0 did not set its flag");
  AST_DEEP_OSC: assert property (pwr_r == ISW_DEEP |-> !oscKeepOn && !progMemOn && timerRun == 3'h0)
    else $error("deep sleep left something running");
  AST_DEEP_STAY: assert property (pwr_r == ISW_DEEP && !pinToggle |=> pwr_r == ISW_DEEP)
    else $error("deep sleep left without pin toggle");
  AST_LIGHT_CLK: assert property (pwr_r == ISW_LIGHT |-> !coreClkEn && slowRcEn && oscKeepOn)
    else $error("light sleep clock gating wrong");
  AST_FAST_WAKE: assert property (pwr_r == ISW_WAKE && fastBootOpt |-> wakeCnt_r < 12'd45)
    else $error("fast wake counted past its target");
endmodule : isw_ctrl

// [verif/isw_rc_model.sv]
// slow rc oscillator model for the far side of the wake-up logic
module isw_rc_model (
  input wire logic slowRcEn,
  output logic slowRcClk
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    slowRcClk = 1'h0;
    forever
    begin
      #18.5;
      slowRcClk = slowRcEn ? ~slowRcClk : 1'h0;
    end
  end
endmodule : isw_rc_model

// [verif/isw_ctrl_tb_top.sv]
// self-checking bench for the interrupt and sleep controller
module isw_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************
  // signals and model state
  // ****************
  logic clk, rst_n, flagWrStb, instrBoundary, engintCmd, disgintCmd, retiCmd, pushafCmd, popafCmd, spWrStb;
  logic lightSleepCmd, deepSleepCmd, fastBootOpt, slowRcClk, globalEnable, irqTake, restoreValid;
  logic coreClkEn, progMemOn, oscKeepOn, slowRcEn, wakeDone;
  logic [1:0] extPinSel;
  logic [2:0] timerClkIsCore, timerOscOn, timerMatch, timerRun;
  logic [3:0] extPins;
  logic [4:0] src;
  logic [6:0] irqLineEnable, flagWrData, irqFlags, expFlags;
  logic [7:0] accumulator, flagReg, spWrData, stackPointer, restoreAcc, restoreFlag, expSp;
  logic [7:0] comparatorControl, comparatorSelect, auxControl;
  logic [13:0] edgeSel, ioPins, portDigitalInputEnable;
  logic [15:0] pcIn, vectorPc, restorePc, top;
  int error_cnt = 0, cmp_count = 0, rcCnt = 0, rcBase, ln, n, lim;
  logic [15:0] stk[$];
  // design and oscillator
  isw_ctrl dut (.clk, .rst_n, .extPins, .extPinSel, .adcEvt(src[0]), .t16Evt(src[1]), .cmpEvt(src[2]),
    .t2Evt(src[3]), .t3Evt(src[4]), .edgeSel, .irqLineEnable, .flagWrStb, .flagWrData, .irqFlags,
    .instrBoundary, .engintCmd, .disgintCmd, .retiCmd, .pushafCmd, .popafCmd, .pcIn, .accumulator,
    .flagReg, .spWrStb, .spWrData, .stackPointer, .globalEnable, .irqTake, .vectorPc, .restoreValid,
    .restorePc, .restoreAcc, .restoreFlag, .lightSleepCmd, .deepSleepCmd, .ioPins, .portDigitalInputEnable,
    .timerClkIsCore, .timerOscOn, .timerMatch, .comparatorControl, .comparatorSelect, .auxControl,
    .fastBootOpt, .slowRcClk, .coreClkEn, .progMemOn, .oscKeepOn, .slowRcEn, .timerRun, .wakeDone);
  isw_rc_model rc (.slowRcEn, .slowRcClk);
  // core clock, 10 ns period
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // slow rc edge counter
  always @(posedge slowRcClk) rcCnt <= rcCnt + 1;
  // ****************
  // tasks
  // ****************
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc
  task automatic pulse(ref logic s);
    s = 1'h1;
    cyc(1);
    s = 1'h0;
  endtask : pulse
  task automatic wrFlags(input logic [6:0] d);
    flagWrData = d;
    pulse(flagWrStb);
    expFlags = expFlags & d;
  endtask : wrFlags
  task automatic waitWake(input int k);
    n = 0;
    while (wakeDone !== 1'h1 && n < k)
    begin
      cyc(1);
      n++;
    end
    chk("wake pulse", 16'h0001, wakeDone);
  endtask : waitWake
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test
  // watchdog against a hang, well past the five wake-up waits
  initial
  begin
    #300us;
    error_cnt++;
    finish_test();
  end
  // ****************
  // main sequence
  // ****************
  initial
  begin
    n = $urandom(32'h90d6);
    {rst_n, flagWrStb, instrBoundary, engintCmd, disgintCmd, retiCmd, pushafCmd, popafCmd, spWrStb} = '0;
    {lightSleepCmd, deepSleepCmd, fastBootOpt, extPinSel, extPins, src, timerMatch, timerClkIsCore} = '0;
    {irqLineEnable, flagWrData, edgeSel, ioPins, comparatorControl, comparatorSelect, auxControl} = '0;
    {accumulator, flagReg, spWrData, pcIn, expFlags, expSp} = '0;
    portDigitalInputEnable = 14'h0008;
    timerOscOn = 3'h7;
    repeat (6) @(negedge clk);
    rst_n = 1'h1;
    cyc(3);
    chk("reset gie", 16'h0000, globalEnable);
    chk("reset timers", 16'h0007, timerRun);
    // every edge code on random lines
    for (int c = 0; c < 4; c++)
    begin
      ln = 2 + $urandom_range(4);
      edgeSel = 14'h0000;
      edgeSel[2*ln +: 2] = c[1:0];
      wrFlags(7'h00);
      src[ln-2] = 1'h1;
      cyc(2);
      if (c != 2) expFlags[ln] = 1'h1;
      chk("flags rise", expFlags, irqFlags);
      src[ln-2] = 1'h0;
      cyc(2);
      if (c != 1) expFlags[ln] = 1'h1;
      chk("flags fall", expFlags, irqFlags);
    end
    wrFlags(7'h00);
    src[1:0] = 2'h3;
    cyc(2);
    expFlags = 7'h0c;
    wrFlags(7'h7b);
    cyc(1);
    chk("clear one", expFlags, irqFlags);
    // external line uses the chosen pin
    extPinSel = 2'h1;
    extPins[0] = 1'h1;
    cyc(6);
    chk("unchosen pin", expFlags, irqFlags);
    extPins[1] = 1'h1;
    cyc(6);
    expFlags[0] = 1'h1;
    chk("chosen pin", expFlags, irqFlags);
    // entry gated by global and line enables
    irqLineEnable = 7'h08;
    instrBoundary = 1'h1;
    #1 chk("take gie off", 16'h0000, irqTake);
    cyc(1);
    instrBoundary = 1'h0;
    spWrData = 8'($urandom_range(60)) << 1;
    expSp = spWrData;
    pulse(spWrStb);
    pulse(engintCmd);
    chk("gie on", 16'h0001, globalEnable);
    pulse(disgintCmd);
    chk("gie off", 16'h0000, globalEnable);
    pulse(engintCmd);
    chk("gie on again", 16'h0001, globalEnable);
    irqLineEnable = 7'h00;
    instrBoundary = 1'h1;
    #1 chk("take line off", 16'h0000, irqTake);
    cyc(1);
    irqLineEnable = 7'h08;
    pcIn = 16'($urandom);
    #1 chk("take", 16'h0001, irqTake);
    chk("vector", 16'h0010, vectorPc);
    cyc(1);
    instrBoundary = 1'h0;
    stk.push_back(pcIn);
    expSp += 8'h02;
    chk("entry sp", expSp, stackPointer);
    chk("entry gie", 16'h0000, globalEnable);
    wrFlags(7'h77);
    // push then pop accumulator and flags
    accumulator = 8'($urandom);
    flagReg = 8'($urandom);
    stk.push_back({accumulator, flagReg});
    pulse(pushafCmd);
    expSp += 8'h02;
    chk("push sp", expSp, stackPointer);
    chk("stack bytes", 16'h0004, 16'(stackPointer - spWrData));
    for (int k = 0; k < 2; k++)
    begin
      top = stk.pop_back();
      if (k == 0) pulse(popafCmd); else pulse(retiCmd);
      expSp -= 8'h02;
      chk("pop sp", expSp, stackPointer);
      chk("pop gie", 16'(k), globalEnable);
      cyc(1);
      chk("restore valid", 16'h0001, restoreValid);
      chk("restored", top, (k == 0) ? {restoreAcc, restoreFlag} : restorePc);
    end
    timerClkIsCore = 3'h1;
    timerOscOn = 3'h5;
    pulse(lightSleepCmd);
    chk("light core clk", 16'h0000, coreClkEn);
    chk("light mem", 16'h0000, progMemOn);
    chk("light rc", 16'h0001, slowRcEn);
    chk("light timers", 16'h0004, timerRun);
    // core-clocked timer and timer with oscillator off must not wake
    timerMatch = 3'h3;
    cyc(4);
    chk("core timer no wake", 16'h0000, coreClkEn);
    timerMatch = 3'h4;
    waitWake(5);
    timerMatch = 3'h0;
    timerOscOn = 3'h7;
    pulse(lightSleepCmd);
    comparatorControl = 8'h80;
    src[2] = 1'h1;
    cyc(4);
    chk("cmp no wake", 16'h0000, coreClkEn);
    src[2] = 1'h0;
    comparatorSelect = 8'h40;
    cyc(1);
    src[2] = 1'h1;
    waitWake(5);
    src[2] = 1'h0;
    // pin wake timing for each speed choice
    for (int i = 0; i < 3; i++)
    begin
      fastBootOpt = (i == 1);
      auxControl = (i == 0) ? 8'h20 : 8'h00;
      lim = (i == 2) ? 3000 : 45;
      if (i == 0) pulse(lightSleepCmd); else pulse(deepSleepCmd);
      chk("osc kept", 16'(i == 0), oscKeepOn);
      timerMatch = (i > 0) ? 3'h7 : 3'h0;
      ioPins[5] = ~ioPins[5];
      cyc(6);
      timerMatch = 3'h0;
      chk("no wake", 16'h0000, coreClkEn);
      rcBase = rcCnt;
      ioPins[3] = ~ioPins[3];
      waitWake(20000);
      chk("rc count", 16'h0001, 16'(rcCnt - rcBase >= lim && rcCnt - rcBase <= lim + 4));
      chk("sp kept", expSp, stackPointer);
    end
    finish_test();
  end
endmodule : isw_ctrl_tb_top
